// >>> shared/mbs_pkg.sv
// Purpose: constants for the station address and function map front end
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes:   the baud, format, parity and delay words are 16 bits and sit in the low half
package mbs_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_SADDR  = 12'h004;
	localparam logic [11:0] OFF_BAUD   = 12'h008;
	localparam logic [11:0] OFF_FMT    = 12'h00c;
	localparam logic [11:0] OFF_PARITY = 12'h010;
	localparam logic [11:0] OFF_DELAY  = 12'h014;
	localparam logic [11:0] OFF_STATUS = 12'h018;
	localparam logic [11:0] OFF_COUNT  = 12'h01c;
	// ==========================================================
	// field positions
	localparam int CTRL_SRC_SW = 0;
	localparam int CTRL_ASCII  = 1;
	localparam int STAT_RESTOR = 14;
	// ==========================================================
	// reset and restored values, and the lowest stored address
	localparam logic [1:0]  CTRL_RST   = 2'h1;
	localparam logic [7:0]  SADDR_RST  = 8'h20;
	localparam logic [7:0]  SADDR_MIN  = 8'h20;
	localparam logic [15:0] BAUD_RST   = 16'h0003;
	localparam logic [15:0] FMT_RST    = 16'h0018;
	localparam logic [15:0] PARITY_RST = 16'h0000;
	localparam logic [15:0] DELAY_RST  = 16'h0000;
	// ==========================================================
	// function codes and exception codes
	localparam logic [7:0] FC_RD_OUTBIT  = 8'h01;
	localparam logic [7:0] FC_RD_INBIT   = 8'h02;
	localparam logic [7:0] FC_RD_INREG   = 8'h03;
	localparam logic [7:0] FC_RD_HOLD    = 8'h04;
	localparam logic [7:0] FC_WR_OUTBIT  = 8'h05;
	localparam logic [7:0] FC_WR_HOLD    = 8'h06;
	localparam logic [7:0] FC_WRN_OUTBIT = 8'h0f;
	localparam logic [7:0] FC_WRN_HOLD   = 8'h10;
	localparam logic [7:0] EXC_FUNC      = 8'h01;
	localparam logic [7:0] EXC_VALUE     = 8'h03;
	// ==========================================================
	// timing: switch settle window after reset release
	localparam logic [2:0] BOOT_CYCLES = 3'h6;
	// ==========================================================
	// data spaces and power-up check states
	typedef enum logic [1:0] {SP_OUTBIT, SP_INBIT, SP_INREG, SP_HOLD} mbs_space_t;
	typedef enum logic [1:0] {BT_SETTLE, BT_CHECK, BT_RUN} mbs_boot_t;
endpackage : mbs_pkg

// >>> core/mbs_front.sv
// Purpose: station address forming and function code map of the serial slave
// Assumes: frame fields come decoded from a framer on ref_clk; switches are pins
// Notes:   one request per frame strobe, answer one cycle later from flops
`timescale 1ns/1ps
// Functional notes
// RULE1: in switch mode the station address is the switch value 0..31.
// RULE2: switches weigh 1,2,4,8,16, first lowest; on adds its weight.
// RULE3: addresses 32..255 come only from software writes, never switches.
// RULE4: bit outputs use codes 1,5,15; bit inputs use code 2.
// RULE5: input registers use code 3; holding registers use codes 4,6,16.
// RULE6: every register is one 16-bit word.
// RULE7: frames of the framing mode not configured are ignored.
// RULE8: restore switch on at power-up reloads defaults and clears stored values.
// RULE9: only frames for our station are answered; others get no reply.
module mbs_front (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// dip switches, asynchronous pins
	input  wire logic        addr_switch_weight1,
	input  wire logic        addr_switch_weight2,
	input  wire logic        addr_switch_weight4,
	input  wire logic        addr_switch_weight8,
	input  wire logic        addr_switch_weight16,
	input  wire logic        restore_defaults_switch,
	// decoded frame from the framer
	input  wire logic        frm_valid,
	input  wire logic        frm_ascii,
	input  wire logic [7:0]  frm_station,
	input  wire logic [7:0]  frm_func,
	input  wire logic [15:0] frm_start,
	input  wire logic [15:0] frm_count,
	// command to the data spaces
	output logic             cmd_valid,
	output logic [1:0]       cmd_space,
	output logic             cmd_write,
	output logic [15:0]      cmd_start,
	output logic [15:0]      cmd_count,
	// exception reply request
	output logic             exc_valid,
	output logic [7:0]       exc_code,
	// settings towards the framer
	output logic [7:0]       station_addr,
	output logic             mode_ascii
);
	// ==========================================================
	// switch synchronisers
	logic [5:0] s1_q, s2_q, s3_q, sw_q, sw_d;
	logic [5:0] pins;
	assign pins = {restore_defaults_switch, addr_switch_weight16, addr_switch_weight8,
		addr_switch_weight4, addr_switch_weight2, addr_switch_weight1}; // RULE2

	// a change counts only once stages two and three agree
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			sw_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : sw_q[i];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= 6'h00;
			s2_q <= 6'h00;
			s3_q <= 6'h00;
			sw_q <= 6'h00;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			sw_q <= sw_d;
		end
	end

	// ==========================================================
	// power-up restore check
	mbs_pkg::mbs_boot_t boot_q, boot_d;
	logic [2:0] bcnt_q, bcnt_d;
	logic       restore_d, restore_q, restored_q, restored_d;

	// wait until the synchroniser is filled before trusting the switch
	always_comb begin
		boot_d     = boot_q;
		bcnt_d     = bcnt_q;
		restore_d  = 1'b0;
		restored_d = restored_q;
		case (boot_q)
			mbs_pkg::BT_SETTLE: begin
				bcnt_d = bcnt_q + 3'h1;
				if (bcnt_q == mbs_pkg::BOOT_CYCLES) boot_d = mbs_pkg::BT_CHECK;
			end
			mbs_pkg::BT_CHECK: begin
				restore_d  = sw_q[5]; // RULE8
				restored_d = sw_q[5];
				boot_d     = mbs_pkg::BT_RUN;
			end
			mbs_pkg::BT_RUN: ;
			default: boot_d = mbs_pkg::BT_SETTLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			boot_q     <= mbs_pkg::BT_SETTLE;
			bcnt_q     <= 3'h0;
			restore_q  <= 1'b0;
			restored_q <= 1'b0;
		end else begin
			boot_q     <= boot_d;
			bcnt_q     <= bcnt_d;
			restore_q  <= restore_d;
			restored_q <= restored_d;
		end
	end

	// ==========================================================
	// configuration registers and apb slave
	logic [1:0]  ctrl_q, ctrl_d;
	logic [7:0]  saddr_q, saddr_d, station_q, station_d;
	logic [15:0] baud_q, baud_d, fmt_q, fmt_d, par_q, par_d, dly_q, dly_d;
	logic [15:0] cnt_q, cnt_d;
	logic [31:0] rdata_d;
	logic        err_d, rdy_d, wr_en, cmd_d;

	assign wr_en = psel && penable && pready && pwrite && !pslverr;

	// decode in setup, answer in the single access cycle
	always_comb begin
		rdy_d   = psel && !penable;
		err_d   = 1'b0;
		rdata_d = 32'h0000_0000;
		case (paddr)
			mbs_pkg::OFF_CTRL:   rdata_d = {30'h0, ctrl_q};
			mbs_pkg::OFF_SADDR: begin
				rdata_d = {24'h0, saddr_q};
				err_d   = pwrite && (pwdata[31:8] != 24'h0 || pwdata[7:0] < mbs_pkg::SADDR_MIN); // RULE3
			end
			mbs_pkg::OFF_BAUD:   rdata_d = {16'h0, baud_q}; // RULE6
			mbs_pkg::OFF_FMT:    rdata_d = {16'h0, fmt_q};
			mbs_pkg::OFF_PARITY: rdata_d = {16'h0, par_q};
			mbs_pkg::OFF_DELAY:  rdata_d = {16'h0, dly_q};
			mbs_pkg::OFF_STATUS: begin
				rdata_d = {17'h0, restored_q, sw_q, station_q};
				err_d   = pwrite;
			end
			mbs_pkg::OFF_COUNT: begin
				rdata_d = {16'h0, cnt_q};
				err_d   = pwrite;
			end
			default: err_d = 1'b1;
		endcase
		if (!rdy_d) begin
			rdata_d = prdata;
			err_d   = pslverr;
		end
	end

	// software writes, with the power-up restore taking priority
	always_comb begin
		ctrl_d  = ctrl_q;
		saddr_d = saddr_q;
		baud_d  = baud_q;
		fmt_d   = fmt_q;
		par_d   = par_q;
		dly_d   = dly_q;
		cnt_d   = cmd_d ? cnt_q + 16'h0001 : cnt_q;
		if (wr_en) begin
			case (paddr)
				mbs_pkg::OFF_CTRL:   ctrl_d  = pwdata[1:0];
				mbs_pkg::OFF_SADDR:  saddr_d = pwdata[7:0]; // RULE3
				mbs_pkg::OFF_BAUD:   baud_d  = pwdata[15:0];
				mbs_pkg::OFF_FMT:    fmt_d   = pwdata[15:0];
				mbs_pkg::OFF_PARITY: par_d   = pwdata[15:0];
				mbs_pkg::OFF_DELAY:  dly_d   = pwdata[15:0];
				default: ;
			endcase
		end
		if (restore_q) begin // RULE8
			ctrl_d  = mbs_pkg::CTRL_RST;
			saddr_d = mbs_pkg::SADDR_RST;
			baud_d  = mbs_pkg::BAUD_RST;
			fmt_d   = mbs_pkg::FMT_RST;
			par_d   = mbs_pkg::PARITY_RST;
			dly_d   = mbs_pkg::DELAY_RST;
			cnt_d   = 16'h0000;
		end
		// switches give only 0..31, stored value only 32..255
		station_d = ctrl_q[mbs_pkg::CTRL_SRC_SW] ? {3'h0, sw_q[4:0]} : saddr_q; // RULE1 RULE3
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q    <= mbs_pkg::CTRL_RST;
			saddr_q   <= mbs_pkg::SADDR_RST;
			baud_q    <= mbs_pkg::BAUD_RST;
			fmt_q     <= mbs_pkg::FMT_RST;
			par_q     <= mbs_pkg::PARITY_RST;
			dly_q     <= mbs_pkg::DELAY_RST;
			cnt_q     <= 16'h0000;
			station_q <= 8'h00;
			prdata    <= 32'h0000_0000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			saddr_q   <= saddr_d;
			baud_q    <= baud_d;
			fmt_q     <= fmt_d;
			par_q     <= par_d;
			dly_q     <= dly_d;
			cnt_q     <= cnt_d;
			station_q <= station_d;
			prdata    <= rdata_d;
			pready    <= rdy_d;
			pslverr   <= err_d;
		end
	end

	// ==========================================================
	// function code interpreter
	// returns {supported, write, space}
	function automatic logic [3:0] fc_map(input logic [7:0] fc);
		case (fc)
			mbs_pkg::FC_RD_OUTBIT:  fc_map = {2'b10, mbs_pkg::SP_OUTBIT}; // RULE4
			mbs_pkg::FC_WR_OUTBIT:  fc_map = {2'b11, mbs_pkg::SP_OUTBIT};
			mbs_pkg::FC_WRN_OUTBIT: fc_map = {2'b11, mbs_pkg::SP_OUTBIT};
			mbs_pkg::FC_RD_INBIT:   fc_map = {2'b10, mbs_pkg::SP_INBIT};
			mbs_pkg::FC_RD_INREG:   fc_map = {2'b10, mbs_pkg::SP_INREG}; // RULE5
			mbs_pkg::FC_RD_HOLD:    fc_map = {2'b10, mbs_pkg::SP_HOLD};
			mbs_pkg::FC_WR_HOLD:    fc_map = {2'b11, mbs_pkg::SP_HOLD};
			mbs_pkg::FC_WRN_HOLD:   fc_map = {2'b11, mbs_pkg::SP_HOLD};
			default:                fc_map = 4'h0;
		endcase
	endfunction : fc_map

	logic [3:0]  fm;
	logic        hit, single, exc_d, wr_d;
	logic [1:0]  sp_d;
	logic [7:0]  code_d;
	logic [15:0] cnt_out_d;

	// a frame for another station or framing leaves the outputs quiet
	always_comb begin
		fm        = fc_map(frm_func);
		single    = frm_func == mbs_pkg::FC_WR_OUTBIT || frm_func == mbs_pkg::FC_WR_HOLD;
		hit       = frm_valid && frm_station == station_q // RULE9
			&& frm_ascii == ctrl_q[mbs_pkg::CTRL_ASCII]; // RULE7
		cmd_d     = 1'b0;
		exc_d     = 1'b0;
		code_d    = exc_code;
		sp_d      = cmd_space;
		wr_d      = cmd_write;
		cnt_out_d = single ? 16'h0001 : frm_count;
		if (hit) begin
			if (!fm[3]) begin
				exc_d  = 1'b1;
				code_d = mbs_pkg::EXC_FUNC;
			end else if (cnt_out_d == 16'h0000) begin
				exc_d  = 1'b1;
				code_d = mbs_pkg::EXC_VALUE;
			end else begin
				cmd_d = 1'b1;
				sp_d  = fm[1:0];
				wr_d  = fm[2];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_valid    <= 1'b0;
			cmd_space    <= 2'h0;
			cmd_write    <= 1'b0;
			cmd_start    <= 16'h0000;
			cmd_count    <= 16'h0000;
			exc_valid    <= 1'b0;
			exc_code     <= 8'h00;
			station_addr <= 8'h00;
			mode_ascii   <= 1'b0;
		end else begin
			cmd_valid    <= cmd_d;
			cmd_space    <= sp_d;
			cmd_write    <= wr_d;
			cmd_start    <= cmd_d ? frm_start : cmd_start;
			cmd_count    <= cmd_d ? cnt_out_d : cmd_count;
			exc_valid    <= exc_d;
			exc_code     <= code_d;
			station_addr <= station_d;
			mode_ascii   <= ctrl_d[mbs_pkg::CTRL_ASCII];
		end
	end

	// ==========================================================
	// assertions
	property p_sw_addr;
		@(posedge ref_clk) disable iff (!arst_n)
		ctrl_q[mbs_pkg::CTRL_SRC_SW] |=> station_q == {3'h0, $past(sw_q[4:0])};
	endproperty
	a_sw_addr: assert property (p_sw_addr) else $error("switch address wrong"); // RULE1 RULE2

	property p_hi_addr;
		@(posedge ref_clk) disable iff (!arst_n)
		!ctrl_q[mbs_pkg::CTRL_SRC_SW] |=> station_q >= mbs_pkg::SADDR_MIN;
	endproperty
	a_hi_addr: assert property (p_hi_addr) else $error("stored address below 32"); // RULE3

	property p_low_reject;
		@(posedge ref_clk) disable iff (!arst_n)
		psel && !penable && pwrite && paddr == mbs_pkg::OFF_SADDR && pwdata < 32'h20
		|=> pslverr && pready ##1 saddr_q == $past(saddr_q, 2);
	endproperty
	a_low_reject: assert property (p_low_reject) else $error("low address accepted"); // RULE3

	sequence s_hit(logic [7:0] fc);
		frm_valid && frm_station == station_q && frm_ascii == ctrl_q[mbs_pkg::CTRL_ASCII]
		&& frm_func == fc && frm_count != 16'h0;
	endsequence
	property p_bit_in;
		@(posedge ref_clk) disable iff (!arst_n)
		s_hit(mbs_pkg::FC_RD_INBIT) |=> cmd_valid && cmd_space == mbs_pkg::SP_INBIT && !cmd_write;
	endproperty
	a_bit_in: assert property (p_bit_in) else $error("code 2 misrouted"); // RULE4

	property p_hold_wr;
		@(posedge ref_clk) disable iff (!arst_n)
		s_hit(mbs_pkg::FC_WRN_HOLD) |=> cmd_valid && cmd_space == mbs_pkg::SP_HOLD && cmd_write;
	endproperty
	a_hold_wr: assert property (p_hold_wr) else $error("code 16 misrouted"); // RULE5

	property p_word16;
		@(posedge ref_clk) disable iff (!arst_n)
		psel && !penable && !pwrite && paddr == mbs_pkg::OFF_BAUD |=> prdata[31:16] == 16'h0;
	endproperty
	a_word16: assert property (p_word16) else $error("word wider than 16 bits"); // RULE6

	property p_mode;
		@(posedge ref_clk) disable iff (!arst_n)
		frm_valid && frm_ascii != ctrl_q[mbs_pkg::CTRL_ASCII] |=> !cmd_valid && !exc_valid;
	endproperty
	a_mode: assert property (p_mode) else $error("wrong framing answered"); // RULE7

	property p_restore;
		@(posedge ref_clk) disable iff (!arst_n)
		restore_q |=> baud_q == mbs_pkg::BAUD_RST && dly_q == 16'h0 && !ctrl_q[mbs_pkg::CTRL_ASCII]
		&& cnt_q == 16'h0 ##1 restored_q;
	endproperty
	a_restore: assert property (p_restore) else $error("defaults not restored"); // RULE8

	property p_station;
		@(posedge ref_clk) disable iff (!arst_n)
		frm_valid && frm_station != station_q |=> !cmd_valid && !exc_valid;
	endproperty
	a_station: assert property (p_station) else $error("foreign frame answered"); // RULE9
endmodule : mbs_front

// >>> bench/mbs_frame_src.sv
// Purpose: stand-in for the framer that hands decoded master frames to the front end
// Assumes: one frame per call, fields valid only with the strobe
// Notes:   between frames the fields show the inverse of the last value
`timescale 1ns/1ps
module mbs_frame_src (
	// clock
	input  wire logic        ref_clk,
	// decoded frame
	output logic             frm_valid,
	output logic             frm_ascii,
	output logic [7:0]       frm_station,
	output logic [7:0]       frm_func,
	output logic [15:0]      frm_start,
	output logic [15:0]      frm_count
);
	// ==========================================================
	// idle at time zero
	initial begin
		frm_valid = 1'b0;
		{frm_ascii, frm_station, frm_func, frm_start, frm_count} = '0;
	end
	// ==========================================================
	// one frame, framing and function code chosen by the master
	task automatic send(input logic a, input logic [7:0] st, input logic [7:0] fc, input logic [15:0] c);
		@(posedge ref_clk);
		frm_valid   <= 1'b1;
		frm_ascii   <= a;
		frm_station <= st;
		frm_func    <= fc;
		frm_start   <= 16'h0040;
		frm_count   <= c;
		@(posedge ref_clk);
		frm_valid   <= 1'b0;
		// stale fields would hide a missing strobe qualifier
		{frm_ascii, frm_station, frm_func, frm_start, frm_count} <= ~{a, st, fc, 16'h0040, c};
	endtask : send
endmodule : mbs_frame_src

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the station address and function map front end
// Assumes: apb answers with one access cycle; frame answer one edge later
// Notes:   restore switch is tried through a second reset
`timescale 1ns/1ps
module tb_top;
	logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  sw;
	logic        rst_sw, frm_valid, frm_ascii, cmd_valid, cmd_write, exc_valid, mode_ascii;
	logic [7:0]  frm_station, frm_func, exc_code, station_addr;
	logic [15:0] frm_start, frm_count, cmd_start, cmd_count;
	logic [1:0]  cmd_space;
	int          fails, checks_done;
	logic [7:0]  fc_tab [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
	logic [1:0]  sp_tab [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h0, 2'h3};
	logic [7:0]  wr_tab = 8'hf0;
	logic [15:0] rv_tab [6] = '{16'h0001, 16'h0020, 16'h0003, 16'h0018, 16'h0000, 16'h0000};

	// ==========================================================
	// design and frame source
	mbs_front u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.addr_switch_weight1(sw[0]), .addr_switch_weight2(sw[1]), .addr_switch_weight4(sw[2]),
		.addr_switch_weight8(sw[3]), .addr_switch_weight16(sw[4]), .restore_defaults_switch(rst_sw),
		.frm_valid(frm_valid), .frm_ascii(frm_ascii), .frm_station(frm_station), .frm_func(frm_func),
		.frm_start(frm_start), .frm_count(frm_count), .cmd_valid(cmd_valid), .cmd_space(cmd_space),
		.cmd_write(cmd_write), .cmd_start(cmd_start), .cmd_count(cmd_count), .exc_valid(exc_valid),
		.exc_code(exc_code), .station_addr(station_addr), .mode_ascii(mode_ascii));
	mbs_frame_src u_src (.ref_clk(ref_clk), .frm_valid(frm_valid), .frm_ascii(frm_ascii),
		.frm_station(frm_station), .frm_func(frm_func), .frm_start(frm_start), .frm_count(frm_count));

	// ==========================================================
	// clock, compare, verdict
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out();
		if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// ==========================================================
	// apb master: hold the request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// right after an edge the outputs still show what that edge sampled
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) begin
				rd = prdata;
				er = pslverr;
				break;
			end
		end
		if (n == 50) chk(32'h1, 32'h0);
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task automatic fr(input logic a, input logic [7:0] st, input logic [7:0] fc, input logic [15:0] c);
		u_src.send(a, st, fc, c);
		#1;
	endtask : fr
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : idle
	task automatic boot();
		arst_n <= 1'b0;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (12) @(posedge ref_clk);
	endtask : boot

	// ==========================================================
	// watchdog, far beyond the few hundred cycles of the tests
	initial begin
		#400us;
		fails++;
		close_out();
	end
	// ==========================================================
	// tests
	initial begin
		fails = 0; checks_done = 0; arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = '0; pwdata = '0; sw = 5'h13; rst_sw = 1'b0;
		boot();
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0);
			chk(rd, 32'(rv_tab[i]));
		end
		chk(32'(station_addr), 32'h13);
		// status: not restored, switches and station as set
		apb(1'b0, 12'h018, 32'h0);
		chk(rd, 32'h0000_1313);
		// one switch at a time: each on adds only its own weight
		for (int i = 0; i < 5; i++) begin
			sw <= 5'(1 << i);
			idle(16);
			chk(32'(station_addr), 32'(1 << i));
		end
		sw <= 5'h1f;
		idle(16);
		chk(32'(station_addr), 32'h1f);
		for (int i = 0; i < 8; i++) begin
			fr(1'b0, 8'h1f, fc_tab[i], 16'h0003);
			chk({cmd_valid, exc_valid, cmd_space, cmd_write, cmd_start}, {1'b1, 1'b0, sp_tab[i], wr_tab[i], 16'h0040});
			chk(32'(cmd_count), (i == 4 || i == 5) ? 32'h1 : 32'h3);
		end
		fr(1'b0, 8'h1f, 8'h07, 16'h0003);
		chk({cmd_valid, exc_valid, exc_code}, {2'b01, 8'h01});
		fr(1'b0, 8'h1f, 8'h03, 16'h0000);
		chk({cmd_valid, exc_valid, exc_code}, {2'b01, 8'h03});
		fr(1'b0, 8'h1e, 8'h03, 16'h0001);
		chk({cmd_valid, exc_valid}, 32'h0);
		fr(1'b1, 8'h1f, 8'h03, 16'h0001);
		chk({cmd_valid, exc_valid}, 32'h0);
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h004, 32'h80);
		chk(32'(er), 32'h0);
		idle(4);
		chk(32'(station_addr), 32'h80);
		apb(1'b1, 12'h004, 32'h10);
		chk(32'(er), 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h80);
		apb(1'b0, 12'h0fc, 32'h0);
		chk(32'(er), 32'h1);
		fr(1'b0, 8'h1f, 8'h04, 16'h0001);
		chk(32'(cmd_valid), 32'h0);
		apb(1'b1, 12'h000, 32'h2);
		idle(4);
		fr(1'b1, 8'h80, 8'h10, 16'h0002);
		chk({cmd_valid, cmd_space, mode_ascii}, {1'b1, 2'h3, 1'b1});
		fr(1'b0, 8'h80, 8'h10, 16'h0002);
		chk(32'(cmd_valid), 32'h0);
		// power-up with restore switch on: a write before the check must be wiped
		rst_sw <= 1'b1;
		arst_n <= 1'b0;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		apb(1'b1, 12'h008, 32'h5);
		idle(12);
		apb(1'b0, 12'h018, 32'h0);
		chk(32'(rd[mbs_pkg::STAT_RESTOR]), 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h3);
		rst_sw <= 1'b0;
		close_out();
	end
endmodule : tb_top
